// File: design/pof_pkg.sv
package pof_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_KEY_IN    = 8'h08;
  localparam logic [7:0] IDX_AOUT1     = 8'h64;
  localparam logic [7:0] IDX_AOUT4     = 8'h67;
  localparam logic [7:0] IDX_KEY_OUT   = 8'h70;
  localparam logic [7:0] IDX_ALARM1    = 8'h76;
  localparam logic [7:0] IDX_ALARM4    = 8'h79;
  localparam logic [7:0] IDX_OP_MSG    = 8'h7a;
  localparam logic [7:0] IDX_TIMEOUT   = 8'h7b;
  localparam logic [7:0] IDX_MACRO_LO  = 8'h7c;
  localparam logic [7:0] IDX_MACRO_HI  = 8'h83;
  localparam logic [7:0] IDX_SETUP     = 8'hd0;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'hd1;
  localparam logic [7:0] IDX_IRQ_EN    = 8'hd2;
  localparam logic [7:0] IDX_IRQ_CLR   = 8'hd3;
  localparam logic [7:0] IDX_SEND_STAT = 8'hd4;

  // ----------------------------------------------------------------
  // fields, reset values, codes
  // ----------------------------------------------------------------
  localparam int          SETUP_ALARM_EN = 0;
  localparam int          SETUP_ALARM_SRC = 1;
  localparam int          SETUP_OP_EN    = 2;
  localparam int          IRQ_TIMEOUT    = 0;
  localparam int          IRQ_KEY        = 1;
  localparam int          IRQ_REPLY      = 2;
  localparam logic [15:0] TIMEOUT_RST    = 16'h003c;
  localparam logic [15:0] TIMEOUT_MIN    = 16'h0002;
  localparam logic [15:0] TIMEOUT_MAX    = 16'h7fff;
  localparam logic [15:0] STAT_TIMEOUT   = 16'hc022;
  localparam logic [15:0] STAT_OK        = 16'h0000;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned RESP_UNIT_MS    = 500;
  localparam int unsigned RESP_UNIT_CYC   =
    RESP_UNIT_MS * 1000000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0][15:0] aout;
    logic [15:0]      key_out;
    logic [3:0][15:0] alarm;
    logic [15:0]      op_msg;
    logic [15:0]      timeout;
    logic [2:0]       setup;
    logic [2:0]       irq_en;
  } pof_regs_t;

  typedef struct packed {
    logic [3:0]       alarm_show;
    logic [3:0][15:0] alarm_num;
    logic             op_show;
    logic [15:0]      op_num;
  } pof_msg_t;

  typedef struct packed {
    logic        done;
    logic        err;
    logic [15:0] code;
  } pof_send_t;

  typedef struct packed {
    logic        bit_we;
    logic [4:0]  bit_idx;
    logic        bit_val;
    logic        word_we;
    logic [1:0]  word_sel;
    logic [31:0] word_val;
  } pof_macro_t;

  typedef enum logic {SND_IDLE, SND_WAIT} pof_snd_t;
endpackage

// File: design/pof_regs.sv
// Behaviour
// - each of four analog channels drives a signed value written by the plc
// - scan start loads keyboard code into key-in and key-out registers
// - effective key issued only after scan done, from key-in and key-out
// - one alarm shown per nonzero number in four alarm registers
// - writing zero into an alarm register removes its message
// - alarms shown only while setup bit 0 is one
// - setup bit 1 picks file registers or temporary storage for alarms
// - nonzero operator message number shows that message
// - zero in operator message register removes the message
// - operator message shown only while setup bit 2 is one
// - operator message raises no alarm; plc stops machine itself
// - no reply before timeout ends buffered send with status c022
// - response timeout 2 to 32767 half-seconds, default 60
// - macro bit variables mirror onto bits of first two macro words
// - 32-bit macro variables fill register pairs, last pair at 130
// - macro output registers written by controller, read-only to plc
`timescale 1ns/1ps
`default_nettype none
module pof_regs
  import pof_pkg::*;
#(
  parameter int unsigned HALF_SEC_CYCLES = RESP_UNIT_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        scan_start,
  input  wire logic        scan_done,
  input  wire logic [15:0] kbd_key_code,
  input  wire logic [3:0][15:0] alarm_tmp_num,
  input  wire pof_macro_t  macro_in,
  input  wire logic        send_start,
  input  wire logic        send_reply,
  output logic [3:0][15:0] analog_output_channel,
  output logic             key_eff_valid,
  output logic [15:0]      key_eff_code,
  output pof_msg_t         msg,
  output pof_send_t        buffered_send_command,
  output logic             irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = old;
    if (s[0]) merge16[7:0] = d[7:0];
    if (s[1]) merge16[15:8] = d[15:8];
  endfunction

  function automatic logic [15:0] clamp_to(input logic [15:0] v);
    if (v < TIMEOUT_MIN)      clamp_to = TIMEOUT_MIN;
    else if (v > TIMEOUT_MAX) clamp_to = TIMEOUT_MAX;
    else                      clamp_to = v;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pof_regs_t         regs_reg, regs_next;
  logic [15:0]       key_in_reg, key_in_next;
  logic [15:0]       macro_reg [8];
  logic [15:0]       macro_next [8];
  logic [2:0]        stat_reg, stat_next;
  logic              aw_full_reg, aw_full_next;
  logic [7:0]        aw_idx_reg, aw_idx_next;
  logic              w_full_reg, w_full_next;
  logic [31:0]       w_data_reg, w_data_next;
  logic [3:0]        w_strb_reg, w_strb_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg, bresp_next;
  logic              rvalid_reg, rvalid_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic [1:0]        rresp_reg, rresp_next;
  pof_msg_t          msg_reg, msg_next;
  logic              kv_reg, kv_next;
  logic [15:0]       kc_reg, kc_next;
  pof_snd_t          snd_reg, snd_next;
  logic [31:0]       pre_reg, pre_next;
  logic [15:0]       units_reg, units_next;
  pof_send_t         send_reg, send_next;
  logic              irq_reg, irq_next;

  logic              wr_go;
  logic [7:0]        ar_idx;
  logic              ev_timeout, ev_reply;

  assign wr_go  = aw_full_reg && w_full_reg && !bvalid_reg;
  assign ar_idx = s_axi_araddr[9:2];

  // ----------------------------------------------------------------
  // axi handshake
  // ----------------------------------------------------------------
  always_comb begin
    aw_full_next = aw_full_reg;
    aw_idx_next  = aw_idx_reg;
    w_full_next  = w_full_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (s_axi_awvalid && !aw_full_reg) begin
      aw_full_next = 1'b1;
      aw_idx_next  = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && !w_full_reg) begin
      w_full_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
      if (!(aw_idx_reg inside {[IDX_AOUT1:IDX_AOUT4], IDX_KEY_OUT,
            [IDX_ALARM1:IDX_TIMEOUT], [IDX_MACRO_LO:IDX_MACRO_HI],
            [IDX_SETUP:IDX_SEND_STAT], IDX_KEY_IN}))
        bresp_next = RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register file writes
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] k;
    logic [2:0] m;
    k           = 2'h0;
    m           = 3'h0;
    regs_next   = regs_reg;
    key_in_next = key_in_reg;
    for (int i = 0; i < 8; i++) macro_next[i] = macro_reg[i];
    stat_next   = stat_reg;
    if (wr_go) begin
      if (aw_idx_reg inside {[IDX_AOUT1:IDX_AOUT4]}) begin
        k = 2'(aw_idx_reg - IDX_AOUT1);
        regs_next.aout[k] = merge16(regs_reg.aout[k], w_data_reg,
                                    w_strb_reg);
      end
      if (aw_idx_reg inside {[IDX_ALARM1:IDX_ALARM4]}) begin
        k = 2'(aw_idx_reg - IDX_ALARM1);
        regs_next.alarm[k] = merge16(regs_reg.alarm[k], w_data_reg,
                                     w_strb_reg);
      end
      case (aw_idx_reg)
        IDX_KEY_OUT: regs_next.key_out =
          merge16(regs_reg.key_out, w_data_reg, w_strb_reg);
        IDX_OP_MSG:  regs_next.op_msg =
          merge16(regs_reg.op_msg, w_data_reg, w_strb_reg);
        IDX_TIMEOUT: regs_next.timeout = clamp_to(
          merge16(regs_reg.timeout, w_data_reg, w_strb_reg));
        IDX_SETUP:   if (w_strb_reg[0]) regs_next.setup = w_data_reg[2:0];
        IDX_IRQ_EN:  if (w_strb_reg[0]) regs_next.irq_en = w_data_reg[2:0];
        IDX_IRQ_CLR: if (w_strb_reg[0])
          stat_next = stat_reg & ~w_data_reg[2:0];
        default: ;
      endcase
      // macro words and key-in ignore plc writes
    end
    // scan start overrides a same-cycle plc write of key-out
    if (scan_start) begin
      key_in_next      = kbd_key_code;
      regs_next.key_out = kbd_key_code;
    end
    // controller side of the macro words
    if (macro_in.bit_we) begin
      m = {2'h0, macro_in.bit_idx[4]};
      macro_next[m][macro_in.bit_idx[3:0]] = macro_in.bit_val;
    end
    if (macro_in.word_we) begin
      m = {macro_in.word_sel, 1'b0};
      macro_next[m]        = macro_in.word_val[15:0];
      macro_next[m + 3'h1] = macro_in.word_val[31:16];
    end
    // events set over a same-cycle clear
    if (ev_timeout) stat_next[IRQ_TIMEOUT] = 1'b1;
    if (ev_reply)   stat_next[IRQ_REPLY]   = 1'b1;
    if (scan_done)  stat_next[IRQ_KEY]     = 1'b1;
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] v;
    v           = 16'h0000;
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (s_axi_arvalid && !rvalid_reg) begin
      rresp_next = RESP_OKAY;
      if (ar_idx inside {[IDX_AOUT1:IDX_AOUT4]})
        v = regs_reg.aout[2'(ar_idx - IDX_AOUT1)];
      else if (ar_idx inside {[IDX_ALARM1:IDX_ALARM4]})
        v = regs_reg.alarm[2'(ar_idx - IDX_ALARM1)];
      else if (ar_idx inside {[IDX_MACRO_LO:IDX_MACRO_HI]})
        v = macro_reg[3'(ar_idx - IDX_MACRO_LO)];
      else begin
        case (ar_idx)
          IDX_KEY_IN:    v = key_in_reg;
          IDX_KEY_OUT:   v = regs_reg.key_out;
          IDX_OP_MSG:    v = regs_reg.op_msg;
          IDX_TIMEOUT:   v = regs_reg.timeout;
          IDX_SETUP:     v = {13'h0000, regs_reg.setup};
          IDX_IRQ_STAT:  v = {13'h0000, stat_reg};
          IDX_IRQ_EN:    v = {13'h0000, regs_reg.irq_en};
          IDX_IRQ_CLR:   v = 16'h0000;
          IDX_SEND_STAT: v = send_reg.code;
          default:       rresp_next = RESP_SLVERR;
        endcase
      end
      rvalid_next = 1'b1;
      rdata_next  = {16'h0000, v};
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // key hand-off, messages, interrupt
  // ----------------------------------------------------------------
  always_comb begin
    // plc copy wins; equal copies give the keyboard code
    kv_next = scan_done;
    kc_next = kc_reg;
    if (scan_done)
      kc_next = (regs_reg.key_out != key_in_reg) ?
                regs_reg.key_out : key_in_reg;
    for (int i = 0; i < 4; i++) begin
      msg_next.alarm_num[i] = regs_reg.setup[SETUP_ALARM_SRC] ?
        alarm_tmp_num[i] : regs_reg.alarm[i];
      msg_next.alarm_show[i] = regs_reg.setup[SETUP_ALARM_EN] &&
        (msg_next.alarm_num[i] != 16'h0000);
    end
    msg_next.op_num  = regs_reg.op_msg;
    // display only; never feeds irq or any stop path
    msg_next.op_show = regs_reg.setup[SETUP_OP_EN] &&
      (regs_reg.op_msg != 16'h0000);
    irq_next = |(stat_reg & regs_reg.irq_en);
  end

  // ----------------------------------------------------------------
  // response monitor for procedural sends
  // ----------------------------------------------------------------
  always_comb begin
    snd_next   = snd_reg;
    pre_next   = pre_reg;
    units_next = units_reg;
    send_next  = send_reg;
    send_next.done = 1'b0;
    ev_timeout = 1'b0;
    ev_reply   = 1'b0;
    case (snd_reg)
      SND_IDLE: begin
        if (send_start) begin
          snd_next   = SND_WAIT;
          pre_next   = 32'h0;
          units_next = regs_reg.timeout;
        end
      end
      SND_WAIT: begin
        // reply wins over a timeout in the same cycle
        if (send_reply) begin
          snd_next       = SND_IDLE;
          ev_reply       = 1'b1;
          send_next.done = 1'b1;
          send_next.err  = 1'b0;
          send_next.code = STAT_OK;
        end else if (pre_reg == 32'(HALF_SEC_CYCLES - 1)) begin
          pre_next   = 32'h0;
          units_next = units_reg - 16'h0001;
          if (units_reg == 16'h0001) begin
            snd_next       = SND_IDLE;
            ev_timeout     = 1'b1;
            send_next.done = 1'b1;
            send_next.err  = 1'b1;
            send_next.code = STAT_TIMEOUT;
          end
        end else begin
          pre_next = pre_reg + 32'h1;
        end
      end
      default: snd_next = SND_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      regs_reg    <= '0;
      regs_reg.timeout <= TIMEOUT_RST;
      key_in_reg  <= 16'h0000;
      for (int i = 0; i < 8; i++) macro_reg[i] <= 16'h0000;
      stat_reg    <= 3'h0;
      aw_full_reg <= 1'b0;
      aw_idx_reg  <= 8'h00;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= RESP_OKAY;
      msg_reg     <= '0;
      kv_reg      <= 1'b0;
      kc_reg      <= 16'h0000;
      snd_reg     <= SND_IDLE;
      pre_reg     <= 32'h0;
      units_reg   <= 16'h0000;
      send_reg    <= '0;
      irq_reg     <= 1'b0;
    end else begin
      regs_reg    <= regs_next;
      key_in_reg  <= key_in_next;
      for (int i = 0; i < 8; i++) macro_reg[i] <= macro_next[i];
      stat_reg    <= stat_next;
      aw_full_reg <= aw_full_next;
      aw_idx_reg  <= aw_idx_next;
      w_full_reg  <= w_full_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      msg_reg     <= msg_next;
      kv_reg      <= kv_next;
      kc_reg      <= kc_next;
      snd_reg     <= snd_next;
      pre_reg     <= pre_next;
      units_reg   <= units_next;
      send_reg    <= send_next;
      irq_reg     <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready         = !aw_full_reg;
  assign s_axi_wready          = !w_full_reg;
  assign s_axi_bvalid          = bvalid_reg;
  assign s_axi_bresp           = bresp_reg;
  assign s_axi_arready         = !rvalid_reg;
  assign s_axi_rvalid          = rvalid_reg;
  assign s_axi_rdata           = rdata_reg;
  assign s_axi_rresp           = rresp_reg;
  assign analog_output_channel = regs_reg.aout;
  assign key_eff_valid         = kv_reg;
  assign key_eff_code          = kc_reg;
  assign msg                   = msg_reg;
  assign buffered_send_command = send_reg;
  assign irq                   = irq_reg;

endmodule // pof_regs
`default_nettype wire

// File: sim/pof_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// port properties
// ----------------------------------------------------------------
module pof_regs_chk
  import pof_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        scan_done,
  input wire logic        key_eff_valid,
  input wire pof_msg_t    msg,
  input wire pof_send_t   buffered_send_command,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  logic [3:0] alarm_nz;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      alarm_nz[i] = |msg.alarm_num[i];
    end
  end

  sequence s_key_issue;
    ##1 key_eff_valid;
  endsequence
  sequence s_done_ends;
    ##1 !buffered_send_command.done;
  endsequence

  property p_key_issue;
    scan_done |-> s_key_issue;
  endproperty
  a_key_issue: assert property (p_key_issue)
    else $error("key not issued after scan end");
  property p_key_only;
    key_eff_valid |-> $past(scan_done);
  endproperty
  a_key_only: assert property (p_key_only)
    else $error("key issued without scan end");
  property p_alarm_show;
    |msg.alarm_show |-> (msg.alarm_show & ~alarm_nz) == 4'h0;
  endproperty
  a_alarm_show: assert property (p_alarm_show)
    else $error("alarm shown for zero number");
  property p_op_show;
    msg.op_show |-> msg.op_num != 16'h0000;
  endproperty
  a_op_show: assert property (p_op_show)
    else $error("operator message shown for zero");
  property p_send_err;
    buffered_send_command.done && buffered_send_command.err
      |-> buffered_send_command.code == STAT_TIMEOUT;
  endproperty
  a_send_err: assert property (p_send_err)
    else $error("timeout code wrong");
  property p_send_ok;
    buffered_send_command.done && !buffered_send_command.err
      |-> buffered_send_command.code == STAT_OK;
  endproperty
  a_send_ok: assert property (p_send_ok)
    else $error("reply code wrong");
  property p_done_pulse;
    buffered_send_command.done |-> s_done_ends;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("send done longer than one cycle");
  property p_rd_upper;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("read upper half not zero");
endmodule // pof_regs_chk

bind pof_regs pof_regs_chk u_chk (
  .clk_sys(clk_sys), .srst(srst), .scan_done(scan_done),
  .key_eff_valid(key_eff_valid), .msg(msg),
  .buffered_send_command(buffered_send_command),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata)
);
`default_nettype wire

// File: sim/pof_plc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// plc scan and controller side model
// ----------------------------------------------------------------
module pof_plc_model
  import pof_pkg::*;
(
  input  wire logic        clk_sys,
  output logic             scan_start,
  output logic             scan_done,
  output logic [15:0]      kbd_key_code,
  output logic [3:0][15:0] alarm_tmp_num,
  output pof_macro_t       macro_in,
  output logic             send_start,
  output logic             send_reply
);
  initial begin
    scan_start    = 1'b0;
    scan_done     = 1'b0;
    kbd_key_code  = 16'h0000;
    alarm_tmp_num = {16'h0044, 16'h0033, 16'h0022, 16'h0011};
    macro_in      = '0;
    send_start    = 1'b0;
    send_reply    = 1'b0;
  end
  task automatic scan_begin(input logic [15:0] code);
    @(posedge clk_sys);
    kbd_key_code <= code;
    scan_start   <= 1'b1;
    @(posedge clk_sys);
    scan_start   <= 1'b0;
    kbd_key_code <= ~code; // keyboard moves on, load must not follow
  endtask
  task automatic scan_end;
    @(posedge clk_sys);
    scan_done <= 1'b1;
    @(posedge clk_sys);
    scan_done <= 1'b0;
  endtask
  task automatic macro_bit(input logic [4:0] idx);
    @(posedge clk_sys);
    macro_in.bit_we  <= 1'b1;
    macro_in.bit_idx <= idx;
    macro_in.bit_val <= 1'b1;
    @(posedge clk_sys);
    macro_in.bit_we  <= 1'b0;
  endtask
  task automatic macro_word(input logic [1:0] sel, input logic [31:0] v);
    @(posedge clk_sys);
    macro_in.word_we  <= 1'b1;
    macro_in.word_sel <= sel;
    macro_in.word_val <= v;
    @(posedge clk_sys);
    macro_in.word_we  <= 1'b0;
  endtask
  task automatic tmp_set(input logic [3:0][15:0] v);
    @(posedge clk_sys);
    alarm_tmp_num <= v;
  endtask
  // gap 0 means the far end never answers
  task automatic send_frame(input int gap);
    @(posedge clk_sys);
    send_start <= 1'b1;
    @(posedge clk_sys);
    send_start <= 1'b0;
    if (gap > 0) begin
      repeat (gap) @(posedge clk_sys);
      send_reply <= 1'b1;
      @(posedge clk_sys);
      send_reply <= 1'b0;
    end
  endtask
endmodule // pof_plc_model
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
// ----------------------------------------------------------------
// register bank bench
// ----------------------------------------------------------------
module tb_top;
  import pof_pkg::*;
  logic             clk_sys, srst, awv, wv, bready, arv, rready;
  logic             awrdy, wrdy, bvalid, arrdy, rvalid, kvalid, irq;
  logic             s_st, s_dn, snd_st, snd_rp;
  logic [11:0]      awaddr, araddr;
  logic [3:0]       wstrb;
  logic [31:0]      wdata, rdata, rdat;
  logic [1:0]       bresp, rresp, resp;
  logic [15:0]      kbd, kcode;
  logic [3:0][15:0] tmp, aout;
  pof_macro_t       mac;
  pof_msg_t         msg;
  pof_send_t        snd;
  int               mismatches, total_checks, cyc, n;
  localparam logic [15:0] AV [4] = '{16'h8000, 16'h7fff, 16'hffff, 16'h0001};
  localparam logic [15:0] TW [4] = '{16'h0001, 16'hffff, 16'h7fff, 16'h0002};
  localparam logic [15:0] TR [4] = '{16'h0002, 16'h7fff, 16'h7fff, 16'h0002};

  pof_regs #(.HALF_SEC_CYCLES(4)) u_dut (
    .clk_sys(clk_sys), .srst(srst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arrdy),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .scan_start(s_st), .scan_done(s_dn),
    .kbd_key_code(kbd), .alarm_tmp_num(tmp), .macro_in(mac),
    .send_start(snd_st), .send_reply(snd_rp),
    .analog_output_channel(aout), .key_eff_valid(kvalid),
    .key_eff_code(kcode), .msg(msg), .buffered_send_command(snd), .irq(irq));
  pof_plc_model u_plc (
    .clk_sys(clk_sys), .scan_start(s_st), .scan_done(s_dn),
    .kbd_key_code(kbd), .alarm_tmp_num(tmp), .macro_in(mac),
    .send_start(snd_st), .send_reply(snd_rp));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches++;
      final_report;
    end
  end
  task automatic wr(input logic [7:0] i, input logic [31:0] v,
                    input logic [3:0] s = 4'hf);
    @(posedge clk_sys);
    awaddr <= {2'b00, i, 2'b00};
    wdata  <= v;
    wstrb  <= s;
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awrdy === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
    end while (awv | wv);
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i);
    @(posedge clk_sys);
    araddr <= {2'b00, i, 2'b00};
    arv    <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (arrdy !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    rdat = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // outputs are registered behind the bank, let them land
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // look 1 ns past each edge; the pulse may already stand on entry
  task automatic wait_done;
    n = 0;
    #1;
    while (snd.done !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK(snd.done, 1'b1)
  endtask

  initial begin
    {srst, awv, wv, bready, arv, rready} = 6'h20;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    rd(IDX_TIMEOUT);
    `CHK(rdat, {16'h0000, TIMEOUT_RST})
    for (int i = 0; i < 4; i++) begin
      wr(IDX_AOUT1 + 8'(i), {16'hdead, AV[i]});
      rd(IDX_AOUT1 + 8'(i));
      `CHK(rdat, {16'h0000, AV[i]})
      `CHK(aout[i], AV[i])
      wr(IDX_TIMEOUT, {16'h0000, TW[i]});
      rd(IDX_TIMEOUT);
      `CHK(rdat[15:0], TR[i])
    end
    wr(IDX_AOUT4, 32'h0000_aa55, 4'h2);
    rd(IDX_AOUT4);
    `CHK(rdat[15:0], 16'haa01)
    u_plc.macro_bit(5'd5);
    u_plc.macro_bit(5'd20);
    u_plc.macro_word(2'd3, 32'h1234_abcd);
    rd(IDX_MACRO_LO);
    `CHK(rdat, 32'h0000_0020)
    rd(IDX_MACRO_LO + 8'h01);
    `CHK(rdat, 32'h0000_0010)
    rd(IDX_MACRO_HI - 8'h01);
    `CHK(rdat, 32'h0000_abcd)
    wr(IDX_MACRO_HI, 32'h0);
    rd(IDX_MACRO_HI);
    `CHK(rdat, 32'h0000_1234)
    wr(IDX_IRQ_EN, 32'h2);
    u_plc.scan_begin(16'h0041);
    rd(IDX_KEY_IN);
    `CHK(rdat, 32'h0000_0041)
    rd(IDX_KEY_OUT);
    `CHK(rdat, 32'h0000_0041)
    wr(IDX_KEY_OUT, 32'h52);
    `CHK(kvalid, 1'b0)
    u_plc.scan_end();
    #1;
    `CHK(kvalid, 1'b1)
    `CHK(kcode, 16'h0052)
    settle;
    `CHK(irq, 1'b1)
    wr(IDX_IRQ_EN, 32'h0);
    settle;
    `CHK(irq, 1'b0)
    wr(IDX_IRQ_EN, 32'h2);
    wr(IDX_IRQ_CLR, 32'h2);
    settle;
    `CHK(irq, 1'b0)
    wr(IDX_ALARM1, 32'h5);
    settle;
    `CHK(msg.alarm_show, 4'h0)
    wr(IDX_SETUP, 32'h1);
    wr(IDX_ALARM4, 32'h9);
    settle;
    `CHK(msg.alarm_show, 4'h9)
    `CHK(msg.alarm_num[3], 16'h0009)
    u_plc.tmp_set({16'h0004, 16'h0003, 16'h0066, 16'h0001});
    wr(IDX_SETUP, 32'h3);
    settle;
    `CHK(msg.alarm_num[1], 16'h0066)
    wr(IDX_SETUP, 32'h1);
    wr(IDX_ALARM1, 32'h0);
    wr(IDX_OP_MSG, 32'h7);
    settle;
    `CHK(msg.alarm_show, 4'h8)
    `CHK(msg.op_show, 1'b0)
    wr(IDX_SETUP, 32'h5);
    wr(IDX_IRQ_EN, 32'h7);
    settle;
    `CHK(msg.op_show, 1'b1)
    `CHK(irq, 1'b0)
    wr(IDX_OP_MSG, 32'h0);
    settle;
    `CHK(msg.op_show, 1'b0)
    wr(IDX_TIMEOUT, 32'h2);
    u_plc.send_frame(0);
    wait_done;
    `CHK(n, 2 * 4)
    `CHK(snd.err, 1'b1)
    rd(IDX_SEND_STAT);
    `CHK(rdat[15:0], STAT_TIMEOUT)
    `CHK(irq, 1'b1)
    u_plc.send_frame(3);
    wait_done;
    `CHK(snd.err, 1'b0)
    `CHK(snd.code, STAT_OK)
    rd(8'hff);
    `CHK(resp, RESP_SLVERR)
    wr(8'hff, 32'h1);
    `CHK(resp, RESP_SLVERR)
    final_report;
  end
endmodule // tb_top
`default_nettype wire
